// file: hw/env_meas_pkg.sv
// constants, register map and state codes of the measurement-cycle block
// assumes one 200 MHz clock and a byte-wide internal register port
package env_meas_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SAMPLE_W = 20;
  localparam int HUM_W = 16;
  localparam int GAS_W = 10;
  localparam int RANGE_W = 4;
  localparam int ACC_W = 24;
  localparam int PROFILES = 10;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_NS = 1000000;
  localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int MS_CNT_W = 18;
  localparam int WAIT_MS_W = 12;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] A_HEAT_TRIM = 8'h00;
  localparam logic [7:0] A_HEAT_RANGE = 8'h02;
  localparam logic [7:0] A_STATUS = 8'h1d;
  localparam logic [7:0] A_PRESS_MSB = 8'h1f;
  localparam logic [7:0] A_PRESS_LSB = 8'h20;
  localparam logic [7:0] A_PRESS_XLSB = 8'h21;
  localparam logic [7:0] A_TEMP_MSB = 8'h22;
  localparam logic [7:0] A_TEMP_LSB = 8'h23;
  localparam logic [7:0] A_TEMP_XLSB = 8'h24;
  localparam logic [7:0] A_HUM_HIGH = 8'h25;
  localparam logic [7:0] A_HUM_LOW = 8'h26;
  localparam logic [7:0] A_GAS_HIGH = 8'h2a;
  localparam logic [7:0] A_GAS_LOW = 8'h2b;
  localparam logic [7:0] A_TARGET_0 = 8'h5a;
  localparam logic [7:0] A_WAIT_0 = 8'h64;
  localparam logic [7:0] A_CTRL_GAS = 8'h71;
  localparam logic [7:0] A_CTRL_HUM = 8'h72;
  localparam logic [7:0] A_CTRL_MEAS = 8'h74;
  localparam logic [7:0] A_CONFIG = 8'h75;
  localparam logic [7:0] A_HCAL_TWO_HIGH = 8'he1;
  localparam logic [7:0] A_HCAL_NIBBLES = 8'he2;
  localparam logic [7:0] A_HCAL_ONE_HIGH = 8'he3;
  localparam logic [7:0] A_HCAL_THREE = 8'he4;
  localparam logic [7:0] A_HCAL_FOUR = 8'he5;
  localparam logic [7:0] A_HCAL_FIVE = 8'he6;
  localparam logic [7:0] A_HCAL_SIX = 8'he7;
  localparam logic [7:0] A_HCAL_SEVEN = 8'he8;
  localparam logic [7:0] A_GCAL_B_LOW = 8'heb;
  localparam logic [7:0] A_GCAL_B_HIGH = 8'hec;
  localparam logic [7:0] A_GCAL_A = 8'hed;
  localparam logic [7:0] A_GCAL_C = 8'hee;

  // ****************************************************************
  // field positions and values
  // ****************************************************************
  localparam int F_OSRS_T = 5;
  localparam int F_OSRS_P = 2;
  localparam int F_FILTER = 2;
  localparam int F_RUN_GAS = 4;
  localparam int F_RANGE = 4;
  localparam int F_MULT = 6;
  localparam logic [1:0] MODE_SLEEP = 2'h0;
  localparam logic [1:0] MODE_FORCED = 2'h1;
  localparam logic [2:0] OSR_SKIP = 3'h0;
  localparam logic [2:0] OSR_MAX_SHIFT = 3'h4;
  localparam logic [19:0] SKIP_MARK = 20'h80000;

  // ****************************************************************
  // state and channel codes
  // ****************************************************************
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CONV = 3'b001,
    S_HEAT = 3'b010,
    S_GAS = 3'b011,
    S_DONE = 3'b100
  } state_t;

  typedef enum logic [1:0] {
    CH_TEMP = 2'b00,
    CH_PRESS = 2'b01,
    CH_HUM = 2'b10,
    CH_GAS = 2'b11
  } chan_t;

endpackage

// file: hw/env_measurement_filter_heater.sv
// measurement cycle: oversampled conversions, filter, heater and gas step
// assumes the serial front end turns host transfers into one-cycle
// register strobes, and the analog side answers each request with
// one adc_valid pulse per sample while the request is held
//
// What this block does
// RULE1: humidity enabled or skipped by three-bit oversampling
// RULE2: humidity result always sixteen-bit raw value
// RULE3: filter only temperature and pressure, twenty bits
// RULE4: new equals old times c-1 plus sample over c
// RULE5: filtered value updates memory and output registers
// RULE6: filter config write resets filter, next sample loads
// RULE7: skipped temperature or pressure keeps memory, outputs skip marker
// RULE8: re-enabled channel filters against retained memory
// RULE9: ten eight-bit hot-plate target codes stored
// RULE10: target code is a heater resistance setpoint
// RULE11: each profile has its own heating duration
// RULE12: heating only after all conversions complete
// RULE13: heating duration from 1 ms to 4032 ms
// RULE14: after heating, measure gas layer resistance
// RULE15: pollable flag sets on new measurement result
// RULE16: host checks gas valid and heater settled
// RULE17: settled flag clear when target not reached
// RULE18: heater range trim at 0x02 bits 5:4
// RULE19: signed heater resistance trim at 0x00
// RULE20: calibration coefficients readable by host
// RULE21: oversampling code zero skips the conversion
// RULE22: mode write 01 triggers one forced cycle
// RULE23: profile selector picks target and duration pair
// RULE24: coefficient one makes the filter transparent
// RULE25: fresh flag sets only after whole cycle
`timescale 1ns/1ps

module env_measurement_filter_heater #(
  parameter int CYC_PER_MS = env_meas_pkg::CYCLES_PER_MS,
  parameter logic [7:0] HEAT_TRIM = 8'h00,  // arbitrary trim value
  parameter logic [1:0] HEAT_RANGE = 2'h0,  // arbitrary trim value
  parameter logic [11:0] HCAL_ONE = 12'h000,
  parameter logic [11:0] HCAL_TWO = 12'h000,
  parameter logic [7:0] HCAL_THREE = 8'h00,
  parameter logic [7:0] HCAL_FOUR = 8'h00,
  parameter logic [7:0] HCAL_FIVE = 8'h00,
  parameter logic [7:0] HCAL_SIX = 8'h00,
  parameter logic [7:0] HCAL_SEVEN = 8'h00,
  parameter logic [7:0] GCAL_A = 8'h00,
  parameter logic [15:0] GCAL_B = 16'h0000,
  parameter logic [7:0] GCAL_C = 8'h00
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [env_meas_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [env_meas_pkg::DATA_W-1:0] reg_wdata,
  output logic [env_meas_pkg::DATA_W-1:0] reg_rdata,
  output logic conv_req,
  output logic [1:0] conv_chan,
  input wire logic adc_valid,
  input wire logic [env_meas_pkg::SAMPLE_W-1:0] adc_sample,
  output logic heater_on,
  output logic [7:0] heater_target,
  input wire logic heater_at_target,
  output logic measuring
);
  import env_meas_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    state_t st;
    chan_t chan;
    logic [2:0] osrs_h;
    logic [2:0] osrs_t;
    logic [2:0] osrs_p;
    logic [1:0] mode;
    logic [2:0] filt;
    logic run_gas;
    logic [3:0] prof;
    logic [PROFILES-1:0][7:0] wait_code;
    logic [PROFILES-1:0][7:0] target;
    logic init_t;
    logic init_p;
    logic [19:0] mem_t;
    logic [19:0] mem_p;
    logic [19:0] out_t;
    logic [19:0] out_p;
    logic [HUM_W-1:0] out_h;
    logic [GAS_W-1:0] gas_adc;
    logic [RANGE_W-1:0] gas_rng;
    logic gas_valid;
    logic heat_stab;
    logic new_data;
    logic [ACC_W-1:0] acc;
    logic [4:0] nsamp;
    logic [MS_CNT_W-1:0] ms_cnt;
    logic [WAIT_MS_W-1:0] ms_left;
    logic conv_req;
    logic heater_on;
    logic [7:0] rdata;
    logic [7:0] tgt;
    logic busy;
  } state_all_t;

  state_all_t s_q, s_d;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [19:0] iir_step(input logic [19:0] m,
                                           input logic [19:0] x,
                                           input logic [2:0] k);
    logic [27:0] t;
    t = ({8'h00, m} << k) - {8'h00, m} + {8'h00, x};
    t = t >> k;
    return t[19:0];
  endfunction

  logic [2:0] osr_cur;
  logic [2:0] shift_cur;
  logic [ACC_W-1:0] acc_next;
  logic [ACC_W-1:0] avg;
  logic last_sample;
  logic [3:0] psel;
  logic [5:0] wait_base;
  logic [WAIT_MS_W-1:0] wait_ms;
  logic ms_tick;
  logic start;

  always_comb begin
    unique case (s_q.chan)
      CH_TEMP: osr_cur = s_q.osrs_t;
      CH_PRESS: osr_cur = s_q.osrs_p;
      default: osr_cur = s_q.osrs_h;
    endcase
    // codes above 16x behave as 16x
    shift_cur = (osr_cur > OSR_MAX_SHIFT) ? OSR_MAX_SHIFT
                                          : osr_cur - 3'h1;
    acc_next = s_q.acc + {{(ACC_W-SAMPLE_W){1'b0}}, adc_sample};
    avg = acc_next >> shift_cur;
    last_sample = (s_q.nsamp == 5'(5'h1 << shift_cur) - 5'h1);
    // an out-of-range selector falls back to profile zero
    psel = (s_q.prof < 4'(PROFILES)) ? s_q.prof : 4'h0;
    wait_base = s_q.wait_code[psel][F_MULT-1:0];
    // 6-bit count times 1, 4, 16 or 64 ms; a zero count is taken as 1
    wait_ms = {6'h00, (wait_base == 6'h00) ? 6'h01 : wait_base}
              << {s_q.wait_code[psel][7:F_MULT], 1'b0};  // [RULE13]
    ms_tick = (s_q.ms_cnt == MS_CNT_W'(CYC_PER_MS - 1));
    start = reg_wr && (reg_addr == A_CTRL_MEAS)
            && (reg_wdata[1:0] == MODE_FORCED)
            && (s_q.st == S_IDLE);  // [RULE22]
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;

    // register writes; mode writes while busy are dropped
    if (reg_wr) begin
      if (reg_addr == A_CTRL_HUM) begin
        s_d.osrs_h = reg_wdata[2:0];  // [RULE1]
      end
      if (reg_addr == A_CTRL_MEAS) begin
        s_d.osrs_t = reg_wdata[F_OSRS_T+:3];
        s_d.osrs_p = reg_wdata[F_OSRS_P+:3];
        if (s_q.st == S_IDLE) begin
          s_d.mode = reg_wdata[1:0];
        end
      end
      if (reg_addr == A_CONFIG) begin
        s_d.filt = reg_wdata[F_FILTER+:3];
        s_d.init_t = 1'b1;  // [RULE6]
        s_d.init_p = 1'b1;  // [RULE6]
      end
      if (reg_addr == A_CTRL_GAS) begin
        s_d.run_gas = reg_wdata[F_RUN_GAS];
        s_d.prof = reg_wdata[3:0];  // [RULE23]
      end
      for (int i = 0; i < PROFILES; i++) begin
        if (reg_addr == A_TARGET_0 + 8'(i)) begin
          s_d.target[i] = reg_wdata;  // [RULE9] [RULE10]
        end
        if (reg_addr == A_WAIT_0 + 8'(i)) begin
          s_d.wait_code[i] = reg_wdata;  // [RULE11]
        end
      end
    end

    unique case (s_q.st)
      S_IDLE: begin
        if (start) begin
          s_d.st = S_CONV;
          s_d.chan = CH_TEMP;
          s_d.new_data = 1'b0;
          s_d.gas_valid = 1'b0;
          s_d.acc = '0;
          s_d.nsamp = '0;
        end
      end
      S_CONV: begin
        if (osr_cur == OSR_SKIP) begin
          // skipped: memory untouched, marker in the temperature or pressure result
          if (s_q.chan == CH_TEMP) begin
            s_d.out_t = SKIP_MARK;  // [RULE7] [RULE21]
          end else if (s_q.chan == CH_PRESS) begin
            s_d.out_p = SKIP_MARK;  // [RULE7] [RULE21]
          end
          s_d.conv_req = 1'b0;
        end else begin
          s_d.conv_req = 1'b1;
          if (adc_valid) begin
            s_d.acc = acc_next;
            s_d.nsamp = s_q.nsamp + 5'h1;
          end
        end
        if (osr_cur == OSR_SKIP || (adc_valid && last_sample)) begin
          if (osr_cur != OSR_SKIP) begin
            unique case (s_q.chan)
              CH_TEMP: begin
                // a pending reset loads the sample unchanged; otherwise
                // the retained memory is used, even after a skip
                s_d.mem_t = s_q.init_t ? avg[19:0]
                  : iir_step(s_q.mem_t, avg[19:0], s_q.filt);  // [RULE4] [RULE8] [RULE24]
                s_d.out_t = s_d.mem_t;  // [RULE3] [RULE5]
                // a config write in this same cycle keeps the reset pending
                s_d.init_t = reg_wr && (reg_addr == A_CONFIG);  // [RULE6]
              end
              CH_PRESS: begin
                s_d.mem_p = s_q.init_p ? avg[19:0]
                  : iir_step(s_q.mem_p, avg[19:0], s_q.filt);  // [RULE4] [RULE8] [RULE24]
                s_d.out_p = s_d.mem_p;  // [RULE3] [RULE5]
                s_d.init_p = reg_wr && (reg_addr == A_CONFIG);  // [RULE6]
              end
              default: begin
                s_d.out_h = avg[HUM_W-1:0];  // [RULE2] [RULE3]
              end
            endcase
          end
          s_d.conv_req = 1'b0;
          s_d.acc = '0;
          s_d.nsamp = '0;
          if (s_q.chan == CH_TEMP) begin
            s_d.chan = CH_PRESS;
          end else if (s_q.chan == CH_PRESS) begin
            s_d.chan = CH_HUM;
          end else if (s_q.run_gas) begin
            // heater starts only once all three channels are done
            s_d.st = S_HEAT;  // [RULE12]
            s_d.heater_on = 1'b1;
            s_d.ms_cnt = '0;
            s_d.ms_left = wait_ms;  // [RULE11] [RULE23]
          end else begin
            s_d.st = S_DONE;
          end
        end
      end
      S_HEAT: begin
        s_d.ms_cnt = ms_tick ? '0 : s_q.ms_cnt + MS_CNT_W'(1);
        if (ms_tick) begin
          s_d.ms_left = s_q.ms_left - WAIT_MS_W'(1);
          if (s_q.ms_left == WAIT_MS_W'(1)) begin
            s_d.heat_stab = heater_at_target;  // [RULE17]
            s_d.heater_on = 1'b0;
            s_d.st = S_GAS;
            s_d.chan = CH_GAS;
            s_d.conv_req = 1'b1;  // [RULE14]
          end
        end
      end
      S_GAS: begin
        if (adc_valid) begin
          s_d.gas_adc = adc_sample[GAS_W-1:0];  // [RULE14]
          s_d.gas_rng = adc_sample[GAS_W+:RANGE_W];
          s_d.gas_valid = 1'b1;
          s_d.conv_req = 1'b0;
          s_d.st = S_DONE;
        end
      end
      S_DONE: begin
        s_d.new_data = 1'b1;  // [RULE15] [RULE25]
        s_d.mode = MODE_SLEEP;
        s_d.st = S_IDLE;
      end
      default: begin
        s_d.st = S_IDLE;
      end
    endcase

    // outputs taken from the next state, so they line up with st and target
    s_d.busy = s_d.st != S_IDLE;
    s_d.tgt = s_d.target[(s_d.prof < 4'(PROFILES)) ? s_d.prof : 4'h0];

    // read data, registered
    s_d.rdata = '0;
    for (int i = 0; i < PROFILES; i++) begin
      if (reg_addr == A_TARGET_0 + 8'(i)) begin
        s_d.rdata = s_q.target[i];
      end
      if (reg_addr == A_WAIT_0 + 8'(i)) begin
        s_d.rdata = s_q.wait_code[i];
      end
    end
    case (reg_addr)
      A_HEAT_TRIM: s_d.rdata = HEAT_TRIM;  // [RULE19]
      A_HEAT_RANGE: s_d.rdata = {2'h0, HEAT_RANGE, 4'h0};  // [RULE18]
      A_STATUS: s_d.rdata = {s_q.new_data, 1'b0,
                             s_q.st != S_IDLE, 1'b0, s_q.prof};
      A_PRESS_MSB: s_d.rdata = s_q.out_p[19:12];
      A_PRESS_LSB: s_d.rdata = s_q.out_p[11:4];
      A_PRESS_XLSB: s_d.rdata = {s_q.out_p[3:0], 4'h0};
      A_TEMP_MSB: s_d.rdata = s_q.out_t[19:12];
      A_TEMP_LSB: s_d.rdata = s_q.out_t[11:4];
      A_TEMP_XLSB: s_d.rdata = {s_q.out_t[3:0], 4'h0};
      A_HUM_HIGH: s_d.rdata = s_q.out_h[15:8];
      A_HUM_LOW: s_d.rdata = s_q.out_h[7:0];
      A_GAS_HIGH: s_d.rdata = s_q.gas_adc[9:2];
      A_GAS_LOW: s_d.rdata = {s_q.gas_adc[1:0], s_q.gas_valid,
                              s_q.heat_stab, s_q.gas_rng};
      A_CTRL_GAS: s_d.rdata = {3'h0, s_q.run_gas, s_q.prof};
      A_CTRL_HUM: s_d.rdata = {5'h00, s_q.osrs_h};
      A_CTRL_MEAS: s_d.rdata = {s_q.osrs_t, s_q.osrs_p, s_q.mode};
      A_CONFIG: s_d.rdata = {3'h0, s_q.filt, 2'h0};
      A_HCAL_TWO_HIGH: s_d.rdata = HCAL_TWO[11:4];  // [RULE20]
      A_HCAL_NIBBLES: s_d.rdata = {HCAL_TWO[3:0], HCAL_ONE[3:0]};
      A_HCAL_ONE_HIGH: s_d.rdata = HCAL_ONE[11:4];
      A_HCAL_THREE: s_d.rdata = HCAL_THREE;
      A_HCAL_FOUR: s_d.rdata = HCAL_FOUR;
      A_HCAL_FIVE: s_d.rdata = HCAL_FIVE;
      A_HCAL_SIX: s_d.rdata = HCAL_SIX;
      A_HCAL_SEVEN: s_d.rdata = HCAL_SEVEN;
      A_GCAL_B_LOW: s_d.rdata = GCAL_B[7:0];
      A_GCAL_B_HIGH: s_d.rdata = GCAL_B[15:8];
      A_GCAL_A: s_d.rdata = GCAL_A;
      A_GCAL_C: s_d.rdata = GCAL_C;
      default: ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.init_t <= 1'b1;
      s_q.init_p <= 1'b1;
      s_q.out_t <= SKIP_MARK;
      s_q.out_p <= SKIP_MARK;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rdata = s_q.rdata;
  assign conv_req = s_q.conv_req;
  assign conv_chan = s_q.chan;
  assign heater_on = s_q.heater_on;
  assign heater_target = s_q.tgt;
  assign measuring = s_q.busy;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence seq_heat_end;
    s_q.st == S_HEAT && ms_tick && s_q.ms_left == WAIT_MS_W'(1);
  endsequence

  sequence seq_temp_skip;
    s_q.st == S_CONV && s_q.chan == CH_TEMP && s_q.osrs_t == OSR_SKIP;
  endsequence

  a_skip_marker: assert property (seq_temp_skip |=>  // [RULE7]
    s_q.out_t == SKIP_MARK && s_q.mem_t == $past(s_q.mem_t))
    else $error("skipped temperature not marked or memory changed");

  a_filter_reset: assert property (  // [RULE6]
    reg_wr && reg_addr == A_CONFIG |=> s_q.init_t && s_q.init_p)
    else $error("filter config write did not reset filter");

  a_mem_to_out: assert property (  // [RULE5]
    s_q.st == S_CONV && s_q.chan == CH_PRESS && adc_valid
    && last_sample && s_q.osrs_p != OSR_SKIP
    |=> s_q.out_p == s_q.mem_p && !s_q.init_p)
    else $error("pressure output differs from filter memory");

  a_heat_alone: assert property (  // [RULE12]
    heater_on |-> s_q.st == S_HEAT && !conv_req)
    else $error("heater on during a conversion");

  a_stab_capture: assert property (  // [RULE17]
    seq_heat_end |=> s_q.st == S_GAS && conv_req
    && s_q.heat_stab == $past(heater_at_target))
    else $error("settled flag not taken at heating end");

  a_target_pick: assert property (  // [RULE23]
    heater_on |-> heater_target == s_q.target[psel])
    else $error("heater target not the selected profile");

  a_trigger: assert property (start |=> s_q.st == S_CONV  // [RULE22]
    && s_q.chan == CH_TEMP ##1 measuring)
    else $error("forced mode write did not start a cycle");

  a_fresh_late: assert property (  // [RULE25]
    $rose(s_q.new_data) |-> $past(s_q.st) == S_DONE && !measuring)
    else $error("fresh flag set before cycle end");

  a_transparent: assert property (  // [RULE24]
    s_q.st == S_CONV && s_q.chan == CH_TEMP && adc_valid && last_sample
    && s_q.osrs_t == 3'h1 && s_q.filt == 3'h0
    |=> s_q.out_t == $past(adc_sample))
    else $error("unity coefficient not transparent");

endmodule  // env_measurement_filter_heater

// file: testbench/adc_heater_model.sv
// far-side model: adc answering conversion requests, hot plate settling
// assumes the block raises conv_req and heater_on from registers
`timescale 1ns/1ps

module adc_heater_model (
  input wire logic clk,
  input wire logic conv_req,
  input wire logic [1:0] conv_chan,
  input wire logic heater_on,
  input wire logic settle_ok,
  input wire logic [3:0][19:0] chan_val,
  output logic adc_valid,
  output logic [19:0] adc_sample,
  output logic heater_at_target
);
  logic [1:0] gap_q = 2'h0;
  initial adc_valid = 1'b0;
  initial adc_sample = 20'h00000;
  // ****
  // samples
  // ****
  // a rest after each pulse, so no pulse lands while conv_req falls
  always @(negedge clk) begin
    adc_valid <= conv_req && gap_q == 2'h0;
    gap_q <= (conv_req && gap_q == 2'h0) ? 2'h3 :
      (gap_q != 2'h0 ? gap_q - 2'h1 : 2'h0);
    // released bus shows a changing pattern: the last sample and its inverse in turn
    adc_sample <= (conv_req && gap_q == 2'h0) ? chan_val[conv_chan] :
      ~adc_sample;
  end
  // settled only while heating and the bench allows it
  assign heater_at_target = heater_on & settle_ok;
endmodule // adc_heater_model

// file: testbench/testbench.sv
// bench for the measurement-cycle block: registers, filter, heater
// assumes the package and the block from hw/, model from testbench/
`timescale 1ns/1ps

`define CHK(what, exp, got) begin comparisons++; \
  if ((got) !== (exp)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", what, exp, got); end end

module testbench;
  import env_meas_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic conv_req, heater_on, heater_at_target, measuring, adc_valid;
  logic [1:0] conv_chan;
  logic [7:0] heater_target;
  logic [19:0] adc_sample;
  logic [3:0][19:0] chan_val = '0;
  logic settle_ok = 1'b1;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int heat_cnt;
  logic [7:0] rd;
  logic [19:0] r20;

  // the other calibration words keep their zero defaults
  env_measurement_filter_heater #(.CYC_PER_MS(4), .HEAT_TRIM(8'h9c),
    .HEAT_RANGE(2'h2), .HCAL_TWO(12'h3c1), .GCAL_B(16'hb2c4)) dut_u (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_req(conv_req),
    .conv_chan(conv_chan), .adc_valid(adc_valid),
    .adc_sample(adc_sample), .heater_on(heater_on),
    .heater_target(heater_target), .heater_at_target(heater_at_target),
    .measuring(measuring));

  adc_heater_model model_u (.clk(clk), .conv_req(conv_req),
    .conv_chan(conv_chan), .heater_on(heater_on), .settle_ok(settle_ok),
    .chan_val(chan_val), .adc_valid(adc_valid), .adc_sample(adc_sample),
    .heater_at_target(heater_at_target));

  // ****
  // register port
  // ****
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  // read data belongs to the address seen one edge earlier
  task automatic rdb(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    rd = reg_rdata;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    rdb(a);
    `CHK($sformatf("reg %h", a), e, rd & m)
  endtask

  task automatic rd20(input logic [7:0] a);
    rdb(a);
    r20[19:12] = rd;
    rdb(a + 8'h01);
    r20[11:4] = rd;
    rdb(a + 8'h02);
    r20[3:0] = rd[7:4];
  endtask

  // one forced cycle, watching the heater while it runs
  task automatic run(input logic [7:0] meas, input logic [7:0] tgt);
    int n;
    heat_cnt = 0;
    wr(A_CTRL_MEAS, meas | {6'h00, MODE_FORCED});
    for (n = 0; n < 3000 && measuring !== 1'b0; n++) begin
      @(negedge clk);
      if (heater_on === 1'b1) begin
        heat_cnt++;
        `CHK("heat_target", tgt, heater_target)
      end
      `CHK("heat_vs_conv", 1'b0, heater_on & conv_req)
    end
    `CHK("cycle_end", 1'b0, measuring)
    rc(A_STATUS, 8'h80, 8'h80);
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_cal;
    rc(A_HEAT_TRIM, 8'h9c, 8'hff);
    rc(A_HEAT_RANGE, 8'h20, 8'h30);
    rc(A_HCAL_TWO_HIGH, 8'h3c, 8'hff);
    rc(A_HCAL_NIBBLES, 8'h10, 8'hff);
    rc(A_HCAL_ONE_HIGH, 8'h00, 8'hff);
    rc(A_HCAL_THREE, 8'h00, 8'hff);
    rc(A_HCAL_SEVEN, 8'h00, 8'hff);
    rc(A_GCAL_B_LOW, 8'hc4, 8'hff);
    rc(A_GCAL_B_HIGH, 8'hb2, 8'hff);
    rc(A_GCAL_A, 8'h00, 8'hff);
    rc(A_GCAL_C, 8'h00, 8'hff);
    rc(8'hf0, 8'h00, 8'hff);
    rc(A_TEMP_MSB, 8'h80, 8'hff);
  endtask

  task automatic t_filter;
    chan_val[0] = 20'h10000;
    chan_val[1] = 20'h40000;
    chan_val[2] = 20'h0abcd;
    wr(A_CTRL_HUM, 8'h01);
    wr(A_CONFIG, 8'h04);
    run(8'h64, 8'h00);
    rd20(A_TEMP_MSB);
    `CHK("temp_init", 20'h10000, r20)
    rd20(A_PRESS_MSB);
    `CHK("press_init", 20'h40000, r20)
    chan_val[0] = 20'h20000;
    chan_val[2] = 20'h01234;
    run(8'h60, 8'h00);
    rd20(A_TEMP_MSB);
    `CHK("temp_filt", 20'h18000, r20)
    rd20(A_PRESS_MSB);
    `CHK("press_skip", SKIP_MARK, r20)
    rc(A_HUM_HIGH, 8'h12, 8'hff);
    rc(A_HUM_LOW, 8'h34, 8'hff);
    chan_val[1] = 20'h60000;
    run(8'h64, 8'h00);
    rd20(A_PRESS_MSB);
    `CHK("press_back", 20'h50000, r20)
    rd20(A_TEMP_MSB);
    `CHK("temp_again", 20'h1c000, r20)
    wr(A_CONFIG, 8'h00);
    run(8'h20, 8'h00);
    rd20(A_TEMP_MSB);
    `CHK("temp_pass", 20'h20000, r20)
    // filter already loaded: a new sample must still pass straight through
    chan_val[0] = 20'h30000;
    run(8'h20, 8'h00);
    rd20(A_TEMP_MSB);
    `CHK("temp_unity", 20'h30000, r20)
    run(8'h04, 8'h00);
    rd20(A_TEMP_MSB);
    `CHK("temp_skip", SKIP_MARK, r20)
  endtask

  task automatic t_gas;
    wr(A_TARGET_0, 8'h11);
    wr(A_TARGET_0 + 8'h03, 8'ha5);
    wr(A_WAIT_0 + 8'h03, 8'h42);
    wr(A_CTRL_GAS, 8'h13);
    chan_val[3] = 20'h02e5b;
    settle_ok = 1'b1;
    run(8'h20, 8'ha5);
    `CHK("heat_len", 32, heat_cnt)
    rc(A_GAS_HIGH, 8'h96, 8'hff);
    rc(A_GAS_LOW, 8'hfb, 8'hff);
    settle_ok = 1'b0;
    run(8'h20, 8'ha5);
    rc(A_GAS_LOW, 8'heb, 8'hff);
  endtask

  // ****
  // run control
  // ****
  task automatic close_out;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ceiling well above the few hundred cycles the scenarios need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    repeat (5) @(negedge clk);
    reset = 1'b0;
    t_cal();
    t_filter();
    t_gas();
    close_out();
  end
endmodule // testbench
